// ### include/cufcr_consts.vh
// constants for the per-channel uart data and frame control registers
`ifndef CUFCR_CONSTS_VH
`define CUFCR_CONSTS_VH
`define CUFCR_CH1_UART_DATA 8'h24
`define CUFCR_CH1_FRAME_CTRL 8'h25
`define CUFCR_CH2_UART_DATA 8'h44
`define CUFCR_CH2_FRAME_CTRL 8'h45
`define CUFCR_UART_RESET 8'h00
`define CUFCR_CTRL_RESET 8'h06
`define CUFCR_BIT_TIMEOUT 0
`define CUFCR_BIT_CHECKSUM 1
`define CUFCR_BIT_ROLE 2
`define CUFCR_BIT_SYNC 3
`define CUFCR_BIT_SKIP 6
`define CUFCR_BIT_RESET 7
`define CUFCR_RELAX_BITS 2'h3
`define CUFCR_STRICT_BITS 2'h0
`define CUFCR_FIFO_WIDTH 8
`define CUFCR_FIFO_DEPTH 16
`define CUFCR_FIFO_AW 4
`endif

// ### src/cufcr_fifo.v
// parameterised byte fifo with valid and ready on both sides
`timescale 1ns/100ps
module cufcr_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // filling side
    input wire inValid,
    output wire inReady,
    input wire [WIDTH-1:0] inData,
    // draining side
    output wire outValid,
    input wire outReady,
    output reg [WIDTH-1:0] outData
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wrPtr_reg;
    reg [AW-1:0] rdPtr_reg;
    reg [AW:0] count_reg;
    reg outValid_reg;
    wire doWrite;
    wire doRead;
    wire loadOut;

    assign inReady = (count_reg != DEPTH[AW:0]);
    assign doWrite = inValid && inReady;
    assign loadOut = !outValid_reg || outReady;
    assign doRead = loadOut && (count_reg != {(AW+1){1'b0}});
    assign outValid = outValid_reg;

    always @(posedge clk)
    begin
        if (doWrite)
        begin
            mem[wrPtr_reg] <= inData;
        end
        if (rst)
        begin
            wrPtr_reg <= {AW{1'b0}};
            rdPtr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
            outValid_reg <= 1'b0;
            outData <= {WIDTH{1'b0}};
        end
        else
        begin
            if (doWrite)
            begin
                wrPtr_reg <= wrPtr_reg + 1'b1;
            end
            if (doRead)
            begin
                rdPtr_reg <= rdPtr_reg + 1'b1;
                outData <= mem[rdPtr_reg];
            end
            if (loadOut)
            begin
                outValid_reg <= doRead;
            end
            if (doWrite && !doRead)
            begin
                count_reg <= count_reg + 1'b1;
            end
            else if (!doWrite && doRead)
            begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule // cufcr_fifo

// ### src/cufcr_regs.v
// two-channel uart data and frame handler control register bank
// Notes on behaviour
// - A write to a channel's uart data register sends that byte unless the transmit fifo is full, a read returns the last byte received.
// - The uart data register is eight bits, read and write, and resets to zero.
// - Timeout bit 0 gives the strict receive timeout, 1 adds three bit times.
// - Checksum bit 1 computes the frame checksum, 0 sends a master message at once with no checksum.
// - Role bit 0 makes the frame handler a slave, 1 a master.
// - Sync bit 1 ties this channel's frame timing to the other channel, but only in master role.
// - Writing 1 to skip resets the frame handler and drops the frame while the cycle counter runs on.
// - Writing 1 to reset resets both the frame handler and the cycle time counter.
`timescale 1ns/100ps
`include "cufcr_consts.vh"
module cufcr_regs (
    // clock and reset
    input wire clk,
    input wire rst,
    // register port from the configuration interface
    input wire [7:0] regAddr,
    input wire regWrite,
    input wire [7:0] regWdata,
    input wire regRead,
    output reg [7:0] regRdata,
    output wire [1:0] uartWrReady,
    // transmit bytes toward each channel's uart, two channels packed
    output wire [1:0] txValid,
    input wire [1:0] txReady,
    output wire [15:0] txData,
    // received bytes from each channel's uart
    input wire [1:0] rxValid,
    input wire [15:0] rxData,
    // frame handler controls per channel
    output wire [1:0] timeoutRelaxSel,
    output wire [3:0] timeoutExtraBits,
    output wire [1:0] checksumEn,
    output wire [1:0] immediateStart,
    output wire [1:0] linkRoleSel,
    output wire [1:0] syncActive,
    output wire [1:0] handlerReset,
    output wire [1:0] cycleCounterReset
);
    // reset image of the control register, split into its fields
    localparam [7:0] CTRL_RESET = `CUFCR_CTRL_RESET;
    localparam [0:0] RST_TIMEOUT = CTRL_RESET[`CUFCR_BIT_TIMEOUT];
    localparam [0:0] RST_CHECKSUM = CTRL_RESET[`CUFCR_BIT_CHECKSUM];
    localparam [0:0] RST_ROLE = CTRL_RESET[`CUFCR_BIT_ROLE];
    localparam [0:0] RST_SYNC = CTRL_RESET[`CUFCR_BIT_SYNC];
    localparam [1:0] RST_EXTRA = RST_TIMEOUT ? `CUFCR_RELAX_BITS : `CUFCR_STRICT_BITS;
    localparam [0:0] RST_IMMEDIATE = ~RST_CHECKSUM;
    localparam [0:0] RST_SYNC_ACT = RST_SYNC & RST_ROLE;

    wire [15:0] ctrlFlat;
    wire [15:0] rxFlat;
    reg [7:0] rdMux;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1)
        begin : gChan
            wire [7:0] dataAddr;
            wire [7:0] ctrlAddr;
            wire dataWr;
            wire ctrlWr;
            reg [7:0] rxByte_reg;
            reg [7:0] rxByte_next;
            reg timeout_reg;
            reg timeout_next;
            reg checksum_reg;
            reg checksum_next;
            reg role_reg;
            reg role_next;
            reg sync_reg;
            reg sync_next;
            reg [1:0] extra_reg;
            reg [1:0] extra_next;
            reg immStart_reg;
            reg immStart_next;
            reg syncAct_reg;
            reg syncAct_next;
            reg skip_next;
            reg reset_reg;
            reg reset_next;
            reg handlerRst_reg;
            reg handlerRst_next;

            assign dataAddr = (ch == 0) ? `CUFCR_CH1_UART_DATA : `CUFCR_CH2_UART_DATA;
            assign ctrlAddr = (ch == 0) ? `CUFCR_CH1_FRAME_CTRL : `CUFCR_CH2_FRAME_CTRL;
            assign dataWr = regWrite && (regAddr == dataAddr);
            assign ctrlWr = regWrite && (regAddr == ctrlAddr);

            // written byte queued for the transmitter
            cufcr_fifo #(
                .WIDTH(`CUFCR_FIFO_WIDTH),
                .DEPTH(`CUFCR_FIFO_DEPTH),
                .AW(`CUFCR_FIFO_AW)
            ) uTxFifo (
                .clk(clk),
                .rst(rst),
                .inValid(dataWr),
                .inReady(uartWrReady[ch]),
                .inData(regWdata),
                .outValid(txValid[ch]),
                .outReady(txReady[ch]),
                .outData(txData[ch*8+7:ch*8])
            );

            // last received byte, a newer byte overwrites the older one
            always @*
            begin
                rxByte_next = rxByte_reg;
                if (rxValid[ch])
                begin
                    rxByte_next = rxData[ch*8+7:ch*8];
                end
            end

            // readable control fields, reserved bits are never stored
            always @*
            begin
                timeout_next = timeout_reg;
                checksum_next = checksum_reg;
                role_next = role_reg;
                sync_next = sync_reg;
                if (ctrlWr)
                begin
                    timeout_next = regWdata[`CUFCR_BIT_TIMEOUT];
                    checksum_next = regWdata[`CUFCR_BIT_CHECKSUM];
                    role_next = regWdata[`CUFCR_BIT_ROLE];
                    sync_next = regWdata[`CUFCR_BIT_SYNC];
                end
            end

            // decoded controls, registered so they move with the fields
            always @*
            begin
                extra_next = timeout_next ? `CUFCR_RELAX_BITS : `CUFCR_STRICT_BITS;
                immStart_next = !checksum_next;
                syncAct_next = sync_next && role_next;
            end

            // write strobes last one cycle and clear themselves
            always @*
            begin
                skip_next = ctrlWr && regWdata[`CUFCR_BIT_SKIP];
                reset_next = ctrlWr && regWdata[`CUFCR_BIT_RESET];
                handlerRst_next = skip_next || reset_next;
            end

            always @(posedge clk)
            begin
                if (rst)
                begin
                    rxByte_reg <= `CUFCR_UART_RESET;
                end
                else
                begin
                    rxByte_reg <= rxByte_next;
                end
            end

            always @(posedge clk)
            begin
                if (rst)
                begin
                    timeout_reg <= RST_TIMEOUT;
                    checksum_reg <= RST_CHECKSUM;
                    role_reg <= RST_ROLE;
                    sync_reg <= RST_SYNC;
                    extra_reg <= RST_EXTRA;
                    immStart_reg <= RST_IMMEDIATE;
                    syncAct_reg <= RST_SYNC_ACT;
                end
                else
                begin
                    timeout_reg <= timeout_next;
                    checksum_reg <= checksum_next;
                    role_reg <= role_next;
                    sync_reg <= sync_next;
                    extra_reg <= extra_next;
                    immStart_reg <= immStart_next;
                    syncAct_reg <= syncAct_next;
                end
            end

            always @(posedge clk)
            begin
                if (rst)
                begin
                    reset_reg <= 1'b0;
                    handlerRst_reg <= 1'b0;
                end
                else
                begin
                    reset_reg <= reset_next;
                    handlerRst_reg <= handlerRst_next;
                end
            end

            assign rxFlat[ch*8+7:ch*8] = rxByte_reg;
            // strobes and reserved bits read as zero
            assign ctrlFlat[ch*8+7:ch*8] = {4'h0, sync_reg, role_reg, checksum_reg, timeout_reg};
            assign timeoutRelaxSel[ch] = timeout_reg;
            assign timeoutExtraBits[ch*2+1:ch*2] = extra_reg;
            assign checksumEn[ch] = checksum_reg;
            assign immediateStart[ch] = immStart_reg;
            assign linkRoleSel[ch] = role_reg;
            assign syncActive[ch] = syncAct_reg;
            assign handlerReset[ch] = handlerRst_reg;
            assign cycleCounterReset[ch] = reset_reg;
        end
    endgenerate

    // read data selected by address, unmapped addresses read zero
    always @*
    begin
        rdMux = 8'h00;
        case (regAddr)
            `CUFCR_CH1_UART_DATA: rdMux = rxFlat[7:0];
            `CUFCR_CH1_FRAME_CTRL: rdMux = ctrlFlat[7:0];
            `CUFCR_CH2_UART_DATA: rdMux = rxFlat[15:8];
            `CUFCR_CH2_FRAME_CTRL: rdMux = ctrlFlat[15:8];
            default: rdMux = 8'h00;
        endcase
    end

    // read data is registered and held until the next read
    always @(posedge clk)
    begin
        if (rst)
        begin
            regRdata <= 8'h00;
        end
        else if (regRead)
        begin
            regRdata <= rdMux;
        end
    end
endmodule // cufcr_regs

// ### verification/cufcr_regs_monitor.sv
// port assertions for the register bank
`timescale 1ns/100ps
module cufcr_regs_monitor (
    // clock and reset
    input wire clk,
    input wire rst,
    // register port
    input wire regWrite,
    input wire regRead,
    input wire [7:0] regAddr,
    input wire [7:0] regWdata,
    input wire [7:0] regRdata,
    // transmit path
    input wire [1:0] uartWrReady,
    input wire [1:0] txValid,
    input wire [1:0] txReady,
    input wire [15:0] txData,
    // frame handler controls
    input wire [1:0] timeoutRelaxSel,
    input wire [3:0] timeoutExtraBits,
    input wire [1:0] checksumEn,
    input wire [1:0] immediateStart,
    input wire [1:0] linkRoleSel,
    input wire [1:0] syncActive,
    input wire [1:0] handlerReset,
    input wire [1:0] cycleCounterReset
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence ctrlWr;
        regWrite && regAddr == 8'h25;
    endsequence
    sequence dataWr;
        regWrite && regAddr == 8'h24 && uartWrReady[0] && !txValid[0];
    endsequence
    a_relax_extra: assert property (timeoutExtraBits[1:0] == (timeoutRelaxSel[0] ? 2'h3 : 2'h0))
        else $error("extra bits");
    a_ctrl_role: assert property (ctrlWr |=> linkRoleSel[0] == $past(regWdata[2])
        && checksumEn[0] == $past(regWdata[1]) && immediateStart[0] != checksumEn[0])
        else $error("role or checksum");
    a_sync_gate: assert property (syncActive[0] |-> linkRoleSel[0]) else $error("sync");
    a_skip_cause: assert property (handlerReset[0] |-> $past(regWrite && regAddr == 8'h25
        && regWdata[7:6] != 2'h0)) else $error("handler strobe");
    a_cycle_reset: assert property (cycleCounterReset[0] |-> handlerReset[0] && $past(regWdata[7]))
        else $error("cycle strobe");
    a_ctrl_read: assert property (regRead && regAddr == 8'h25 |=> regRdata[7:4] == 4'h0)
        else $error("control read");
    a_tx_launch: assert property (dataWr |-> ##[1:2] txValid[0]) else $error("tx launch");
    a_tx_hold: assert property (txValid[0] && !txReady[0] |=> txValid[0] && $stable(txData[7:0]))
        else $error("tx hold");
endmodule // cufcr_regs_monitor

// ### verification/cufcr_tb.sv
// register bank testbench
`timescale 1ns/100ps
module tb;
    reg clk = 1'b0, rst = 1'b1, regWrite = 1'b0, regRead = 1'b0, stall = 1'b1;
    reg [7:0] regAddr = 8'h0, regWdata = 8'h0, a, v;
    wire [7:0] regRdata;
    wire [1:0] uartWrReady, txValid, txReady, rxValid, timeoutRelaxSel, checksumEn;
    wire [1:0] immediateStart, linkRoleSel, syncActive, handlerReset, cycleCounterReset;
    wire [3:0] timeoutExtraBits;
    wire [15:0] txData, rxData, lastTx;
    wire [11:0] txCnt;
    integer mismatches = 0, check_count = 0, c, n, k;
    always #50 clk = ~clk;
    cufcr_regs dut_u (.clk, .rst, .regAddr, .regWrite, .regWdata, .regRead, .regRdata,
        .uartWrReady, .txValid, .txReady, .txData, .rxValid, .rxData, .timeoutRelaxSel,
        .timeoutExtraBits, .checksumEn, .immediateStart, .linkRoleSel, .syncActive,
        .handlerReset, .cycleCounterReset);
    cufcr_uart_model far_u (.clk, .stall, .txValid, .txData, .txReady, .rxValid, .rxData,
        .lastTx, .txCnt);
    task chk(input [15:0] g, e);
    begin
        check_count = check_count + 1;
        if (g !== e)
        begin
            mismatches = mismatches + 1;
            $display("Error %0t: got %h want %h", $time, g, e);
        end
    end
    endtask
    task acc(input [7:0] ad, d, input w);
    begin
        @(posedge clk) #1;
        regAddr = ad;
        regWdata = d;
        regWrite = w;
        regRead = !w;
        @(posedge clk) #1;
        regWrite = 1'b0;
        regRead = 1'b0;
        if (!w)
            chk({8'h0, regRdata}, {8'h0, d});
    end
    endtask
    task wrap_up;
    begin
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    end
    endtask
    initial
    begin
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        acc(8'h30, 8'h00, 1'b0);
        for (c = 0; c < 2; c = c + 1)
        begin
            a = c ? 8'h44 : 8'h24;
            acc(a, 8'h00, 1'b0);
            acc(a + 8'h1, 8'h06, 1'b0);
            for (k = 0; k < 4; k = k + 1)
            begin
                v = k[1] ? (k[0] ? 8'h3E : 8'h81) : (k[0] ? 8'h48 : 8'hFF);
                acc(a + 8'h1, v, 1'b1);
                chk({7'h0, timeoutRelaxSel[c], timeoutExtraBits[2*c+:2], checksumEn[c],
                    immediateStart[c], linkRoleSel[c], syncActive[c], handlerReset[c],
                    cycleCounterReset[c]}, {7'h0, v[0], v[0], v[0], v[1], ~v[1], v[2],
                    v[3] & v[2], v[6] | v[7], v[7]});
                acc(a + 8'h1, v & 8'h0F, 1'b0);
            end
            far_u.sendRx(c, ~a);
            for (n = 0; uartWrReady[c] && n < 20; n = n + 1)
                acc(a, a + n[7:0], 1'b1);
            chk(n[15:0], 16'd17);
            acc(a, 8'hEE, 1'b1);
            acc(a, ~a, 1'b0);
            stall = 1'b0;
            for (k = 0; k < 60 && txCnt[6*c+:6] != 6'd17; k = k + 1)
                @(posedge clk);
            #1 stall = 1'b1;
            chk({10'h0, txCnt[6*c+:6]}, 16'd17);
            chk({8'h0, lastTx[8*c+:8]}, {8'h0, a + 8'h10});
        end
        @(posedge clk) #1 rst = 1'b1;
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        acc(8'h24, 8'h00, 1'b0);
        acc(8'h45, 8'h06, 1'b0);
        chk({7'h0, timeoutRelaxSel[1], timeoutExtraBits[3:2], checksumEn[1], immediateStart[1],
            linkRoleSel[1], syncActive[1], handlerReset[1], cycleCounterReset[1]}, 16'h0028);
        wrap_up;
    end
    initial
    begin
        #2000000;
        mismatches = mismatches + 1;
        wrap_up;
    end
endmodule // tb
bind cufcr_regs cufcr_regs_monitor mon_u (.clk, .rst, .regAddr, .regWrite, .regWdata,
    .regRead, .regRdata, .uartWrReady, .txValid, .txReady, .txData, .timeoutRelaxSel,
    .timeoutExtraBits, .checksumEn, .immediateStart, .linkRoleSel, .syncActive,
    .handlerReset, .cycleCounterReset);

// ### verification/cufcr_uart_model.sv
// far side uart model
`timescale 1ns/100ps
module cufcr_uart_model (
    // clock and back pressure control
    input wire clk,
    input wire stall,
    // bytes from the register bank
    input wire [1:0] txValid,
    input wire [15:0] txData,
    output wire [1:0] txReady,
    // bytes toward the register bank
    output reg [1:0] rxValid = 2'h0,
    output reg [15:0] rxData = 16'hA5A5,
    // observation of accepted bytes
    output reg [15:0] lastTx = 16'h0,
    output reg [11:0] txCnt = 12'h0
);
    integer i;
    assign txReady = {2{~stall}};
    always @(posedge clk)
        for (i = 0; i < 2; i = i + 1)
            if (txValid[i] && txReady[i])
            begin
                lastTx[8*i+:8] <= txData[8*i+:8];
                txCnt[6*i+:6] <= txCnt[6*i+:6] + 6'h1;
            end
    task sendRx(input integer c, input [7:0] b);
    begin
        @(posedge clk) #1;
        rxValid[c] = 1'b1;
        rxData[8*c+:8] = b;
        @(posedge clk) #1;
        rxValid[c] = 1'b0;
        rxData = ~rxData;
    end
    endtask
endmodule // cufcr_uart_model
